// File: rtl/kmd_defines.vh
/*
 * Constants of the keypad menu and display controller: menu state
 * codes, display symbols, segment patterns, timing and reset values.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef KMD_DEFINES_VH
`define KMD_DEFINES_VH

// ----------------------------------------------------------------
// Menu states, one-hot
// ----------------------------------------------------------------
`define KMD_ST_MON   4'h1
`define KMD_ST_GRP   4'h2
`define KMD_ST_CODE  4'h4
`define KMD_ST_VAL   4'h8

// ----------------------------------------------------------------
// Readout layout
// ----------------------------------------------------------------
`define KMD_DIGITS   4
`define KMD_SEGS     7
`define KMD_SYM_W    5
`define KMD_EDIT_DIG 0

// ----------------------------------------------------------------
// Display symbols beyond the hex digits, and the hex E and A used for fault and warning
// ----------------------------------------------------------------
`define KMD_SYM_DASH  5'h10
`define KMD_SYM_P     5'h11
`define KMD_SYM_BLANK 5'h12
`define KMD_SYM_FLT   5'h0E
`define KMD_SYM_WRN   5'h0A

// ----------------------------------------------------------------
// Segment patterns, bit order g f e d c b a
// ----------------------------------------------------------------
`define KMD_SEG_DASH  7'h40
`define KMD_SEG_P     7'h73
`define KMD_SEG_BLANK 7'h00

// ----------------------------------------------------------------
// Menu limits and reset values
// ----------------------------------------------------------------
`define KMD_CODE_MAX  8'h63
`define KMD_GRP_RST   4'h0
`define KMD_CODE_RST  8'h00
`define KMD_VAL_RST   16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define KMD_CLK_MHZ       125
`define KMD_BLINK_HALF_MS 250
`define KMD_BLINK_HALF_CYC (`KMD_BLINK_HALF_MS * `KMD_CLK_MHZ * 1000)
`define KMD_BLINK_W       25

`endif

// File: rtl/kmd_panel_ctrl.v
/*
 * Front-panel controller: keys and rotary encoder in, menu state
 * machine, four-digit seven-segment readout and status lamps out.
 * Assumes raw key and encoder pins (active high, already debounced
 * by the panel hardware) and drive-core status on core_clk.
 */
`timescale 1ns/1ns
`include "kmd_defines.vh"

module kmd_panel_ctrl #(
    parameter BLINK_HALF_CYC = `KMD_BLINK_HALF_CYC
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        program_exit_key,
    input  wire        enter_key,
    input  wire        enc_a,
    input  wire        enc_b,
    input  wire        drive_running,
    input  wire        drive_dir_fwd,
    input  wire        run_src_keypad,
    input  wire        fault_active,
    input  wire [7:0]  fault_code,
    input  wire        warning_active,
    input  wire [7:0]  warning_code,
    input  wire [15:0] monitor_value,
    input  wire        keypad_setting_en,
    input  wire [15:0] param_rd_data,
    output wire [27:0] seg_out,
    output wire        running_lamp,
    output wire        forward_lamp,
    output wire        reverse_lamp,
    output wire        remote_lamp,
    output wire        fault_lamp,
    output wire [11:0] param_addr,
    output wire        param_wr_en,
    output wire [15:0] param_wr_data,
    output wire        setpoint_up,
    output wire        setpoint_down,
    output wire        edit_active
);

// ----------------------------------------------------------------
// Segment decoding
// ----------------------------------------------------------------
function [6:0] kmd_seg7;
    input [4:0] sym;
    begin
        case (sym)
            5'h00: kmd_seg7 = 7'h3F;
            5'h01: kmd_seg7 = 7'h06;
            5'h02: kmd_seg7 = 7'h5B;
            5'h03: kmd_seg7 = 7'h4F;
            5'h04: kmd_seg7 = 7'h66;
            5'h05: kmd_seg7 = 7'h6D;
            5'h06: kmd_seg7 = 7'h7D;
            5'h07: kmd_seg7 = 7'h07;
            5'h08: kmd_seg7 = 7'h7F;
            5'h09: kmd_seg7 = 7'h6F;
            5'h0A: kmd_seg7 = 7'h77;
            5'h0B: kmd_seg7 = 7'h7C;
            5'h0C: kmd_seg7 = 7'h39;
            5'h0D: kmd_seg7 = 7'h5E;
            5'h0E: kmd_seg7 = 7'h79;
            5'h0F: kmd_seg7 = 7'h71;
            `KMD_SYM_DASH: kmd_seg7 = `KMD_SEG_DASH;
            `KMD_SYM_P:    kmd_seg7 = `KMD_SEG_P;
            default:       kmd_seg7 = `KMD_SEG_BLANK;
        endcase
    end
endfunction

function [4:0] kmd_hex;
    input [3:0] nib;
    begin
        kmd_hex = {1'b0, nib};
    end
endfunction

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg  [3:0]  sync1_reg;
reg  [3:0]  sync2_reg;
reg  [3:0]  prev_reg;
reg  [3:0]  state_reg;
reg  [3:0]  state_next;
reg  [3:0]  grp_reg;
reg  [7:0]  code_reg;
reg  [15:0] edit_reg;
reg  [11:0] addr_reg;
reg         wr_en_reg;
reg  [15:0] wr_data_reg;
reg         up_reg;
reg         down_reg;
reg         run_lamp_reg;
reg         fwd_lamp_reg;
reg         rev_lamp_reg;
reg         rem_lamp_reg;
reg         flt_lamp_reg;
reg  [`KMD_BLINK_W-1:0] blink_cnt_reg;
reg         blink_reg;
reg  [27:0] seg_reg;
reg  [19:0] sym_vec;
wire [27:0] seg_next;
wire        prog_press;
wire        enter_press;
wire        enc_step;
wire        step_cw;
wire        step_ccw;
wire        in_edit;

// ----------------------------------------------------------------
// Pin synchronisers and edge detection
// ----------------------------------------------------------------
// Bit order: 0 prog/exit, 1 enter, 2 encoder A, 3 encoder B
always @(posedge core_clk) begin
    if (!reset_n) begin
        sync1_reg <= 4'h0;
        sync2_reg <= 4'h0;
        prev_reg  <= 4'h0;
    end else begin
        sync1_reg <= {enc_b, enc_a, enter_key, program_exit_key};
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
    end
end

assign prog_press  = sync2_reg[0] & ~prev_reg[0];
assign enter_press = sync2_reg[1] & ~prev_reg[1];
// One count per detent on A rising; B level gives direction
assign enc_step    = sync2_reg[2] & ~prev_reg[2];
assign step_cw     = enc_step & ~sync2_reg[3];
assign step_ccw    = enc_step & sync2_reg[3];
assign in_edit     = (state_reg == `KMD_ST_VAL);

// ----------------------------------------------------------------
// Menu state machine
// ----------------------------------------------------------------
// A fault or warning display is the monitoring state, so the
// program/exit key toggles it with the group menu for free.
always @* begin
    state_next = state_reg;
    case (state_reg)
        `KMD_ST_MON: begin
            if (prog_press) begin
                state_next = `KMD_ST_GRP;
            end
        end
        `KMD_ST_GRP: begin
            if (prog_press) begin
                state_next = `KMD_ST_MON;
            end else if (enter_press) begin
                state_next = `KMD_ST_CODE;
            end
        end
        `KMD_ST_CODE: begin
            if (prog_press) begin
                state_next = `KMD_ST_GRP;
            end else if (enter_press) begin
                state_next = `KMD_ST_VAL;
            end
        end
        `KMD_ST_VAL: begin
            if (prog_press || enter_press) begin
                state_next = `KMD_ST_CODE;
            end
        end
        default: begin
            state_next = `KMD_ST_MON;
        end
    endcase
end

// ----------------------------------------------------------------
// Menu items, edit value and storage port
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (!reset_n) begin
        state_reg   <= `KMD_ST_MON;
        grp_reg     <= `KMD_GRP_RST;
        code_reg    <= `KMD_CODE_RST;
        edit_reg    <= `KMD_VAL_RST;
        addr_reg    <= 12'h000;
        wr_en_reg   <= 1'b0;
        wr_data_reg <= `KMD_VAL_RST;
        up_reg      <= 1'b0;
        down_reg    <= 1'b0;
    end else begin
        state_reg <= state_next;
        addr_reg  <= {grp_reg, code_reg};
        wr_en_reg <= 1'b0;
        up_reg    <= 1'b0;
        down_reg  <= 1'b0;
        case (state_reg)
            `KMD_ST_MON: begin
                if (keypad_setting_en) begin
                    up_reg   <= step_cw;
                    down_reg <= step_ccw;
                end
            end
            `KMD_ST_GRP: begin
                if (enter_press) begin
                    code_reg <= `KMD_CODE_RST;
                end else if (step_cw) begin
                    grp_reg <= grp_reg + 4'h1;
                end else if (step_ccw) begin
                    grp_reg <= grp_reg - 4'h1;
                end
            end
            `KMD_ST_CODE: begin
                if (enter_press) begin
                    edit_reg <= param_rd_data;
                end else if (step_cw) begin
                    // Wraps so the knob never sticks at either end
                    code_reg <= (code_reg >= `KMD_CODE_MAX) ? `KMD_CODE_RST
                                : code_reg + 8'h01;
                end else if (step_ccw) begin
                    code_reg <= (code_reg == `KMD_CODE_RST) ? `KMD_CODE_MAX
                                : code_reg - 8'h01;
                end
            end
            `KMD_ST_VAL: begin
                if (enter_press) begin
                    wr_en_reg   <= 1'b1;
                    wr_data_reg <= edit_reg;
                end else if (step_cw) begin
                    edit_reg <= edit_reg + 16'h0001;
                end else if (step_ccw) begin
                    edit_reg <= edit_reg - 16'h0001;
                end
            end
            default: begin
                edit_reg <= `KMD_VAL_RST;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Status lamps
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (!reset_n) begin
        run_lamp_reg <= 1'b0;
        fwd_lamp_reg <= 1'b0;
        rev_lamp_reg <= 1'b0;
        rem_lamp_reg <= 1'b0;
        flt_lamp_reg <= 1'b0;
    end else begin
        run_lamp_reg <= drive_running;
        fwd_lamp_reg <= drive_running & drive_dir_fwd;
        rev_lamp_reg <= drive_running & ~drive_dir_fwd;
        rem_lamp_reg <= ~run_src_keypad;
        flt_lamp_reg <= fault_active;
    end
end

// ----------------------------------------------------------------
// Blink timebase
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (!reset_n) begin
        blink_cnt_reg <= {`KMD_BLINK_W{1'b0}};
        blink_reg     <= 1'b0;
    end else if (blink_cnt_reg >= BLINK_HALF_CYC[`KMD_BLINK_W-1:0] - 1'b1) begin
        blink_cnt_reg <= {`KMD_BLINK_W{1'b0}};
        blink_reg     <= ~blink_reg;
    end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
end

// ----------------------------------------------------------------
// Readout content, digit 3 leftmost
// ----------------------------------------------------------------
always @* begin
    sym_vec = {4{`KMD_SYM_BLANK}};
    case (state_reg)
        `KMD_ST_MON: begin
            if (fault_active) begin
                sym_vec = {`KMD_SYM_FLT, `KMD_SYM_DASH,
                           kmd_hex(fault_code[7:4]),
                           kmd_hex(fault_code[3:0])};
            end else if (warning_active) begin
                sym_vec = {`KMD_SYM_WRN, `KMD_SYM_DASH,
                           kmd_hex(warning_code[7:4]),
                           kmd_hex(warning_code[3:0])};
            end else begin
                sym_vec = {kmd_hex(monitor_value[15:12]),
                           kmd_hex(monitor_value[11:8]),
                           kmd_hex(monitor_value[7:4]),
                           kmd_hex(monitor_value[3:0])};
            end
        end
        `KMD_ST_GRP: begin
            sym_vec = {`KMD_SYM_DASH, `KMD_SYM_P,
                       kmd_hex(grp_reg), `KMD_SYM_DASH};
        end
        `KMD_ST_CODE: begin
            sym_vec = {`KMD_SYM_P, kmd_hex(grp_reg),
                       kmd_hex(code_reg[7:4]), kmd_hex(code_reg[3:0])};
        end
        `KMD_ST_VAL: begin
            sym_vec = {kmd_hex(edit_reg[15:12]), kmd_hex(edit_reg[11:8]),
                       kmd_hex(edit_reg[7:4]), kmd_hex(edit_reg[3:0])};
        end
        default: begin
            sym_vec = {4{`KMD_SYM_BLANK}};
        end
    endcase
end

genvar gi;
generate
    for (gi = 0; gi < `KMD_DIGITS; gi = gi + 1) begin : g_digit
        // Only the edited digit goes dark on the blink phase
        assign seg_next[gi*`KMD_SEGS +: `KMD_SEGS] =
            (in_edit && blink_reg && gi == `KMD_EDIT_DIG) ? `KMD_SEG_BLANK
            : kmd_seg7(sym_vec[gi*`KMD_SYM_W +: `KMD_SYM_W]);
    end
endgenerate

always @(posedge core_clk) begin
    if (!reset_n) begin
        seg_reg <= 28'h0000000;
    end else begin
        seg_reg <= seg_next;
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign seg_out       = seg_reg;
assign running_lamp  = run_lamp_reg;
assign forward_lamp  = fwd_lamp_reg;
assign reverse_lamp  = rev_lamp_reg;
assign remote_lamp   = rem_lamp_reg;
assign fault_lamp    = flt_lamp_reg;
assign param_addr    = addr_reg;
assign param_wr_en   = wr_en_reg;
assign param_wr_data = wr_data_reg;
assign setpoint_up   = up_reg;
assign setpoint_down = down_reg;
assign edit_active   = state_reg[3];

endmodule

// File: tb/kmd_panel_ctrl_monitor.sv
/*
 * Checker of the panel controller's lamps, pulses and reset state.
 * Assumes it is bound to kmd_panel_ctrl and sees only its ports.
 */
`timescale 1ns/1ns
module kmd_panel_ctrl_monitor (
    input wire        core_clk,
    input wire        reset_n,
    input wire        drive_running,
    input wire        drive_dir_fwd,
    input wire        run_src_keypad,
    input wire        fault_active,
    input wire        keypad_setting_en,
    input wire [27:0] seg_out,
    input wire        running_lamp,
    input wire        forward_lamp,
    input wire        reverse_lamp,
    input wire        remote_lamp,
    input wire        fault_lamp,
    input wire        param_wr_en,
    input wire        setpoint_up,
    input wire        setpoint_down,
    input wire        edit_active
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_run_lamp: assert property ($past(reset_n) |-> running_lamp == $past(drive_running))
        else $error("running lamp wrong");
    a_fwd_lamp: assert property ($past(reset_n) |->
        forward_lamp == ($past(drive_running) && $past(drive_dir_fwd)))
        else $error("forward lamp wrong");
    a_rev_lamp: assert property ($past(reset_n) |->
        reverse_lamp == ($past(drive_running) && !$past(drive_dir_fwd)))
        else $error("reverse lamp wrong");
    a_remote_lamp: assert property ($past(reset_n) |-> remote_lamp == !$past(run_src_keypad))
        else $error("remote lamp wrong");
    a_fault_lamp: assert property ($past(reset_n) |-> fault_lamp == $past(fault_active))
        else $error("fault lamp wrong");
    a_commit_leaves_edit: assert property (param_wr_en |-> $fell(edit_active) ##1 !param_wr_en)
        else $error("commit pulse wrong");
    a_reset_idle: assert property ($rose(reset_n) |-> !edit_active && seg_out == 28'h0)
        else $error("not idle after reset");
    a_setpoint_gate: assert property ((setpoint_up || setpoint_down) |->
        $past(keypad_setting_en) && !edit_active && !(setpoint_up && setpoint_down))
        else $error("setpoint pulse without keypad setting");
endmodule

bind kmd_panel_ctrl kmd_panel_ctrl_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
    .drive_running(drive_running), .drive_dir_fwd(drive_dir_fwd),
    .run_src_keypad(run_src_keypad), .fault_active(fault_active),
    .keypad_setting_en(keypad_setting_en), .seg_out(seg_out), .running_lamp(running_lamp),
    .forward_lamp(forward_lamp), .reverse_lamp(reverse_lamp), .remote_lamp(remote_lamp),
    .fault_lamp(fault_lamp), .param_wr_en(param_wr_en), .setpoint_up(setpoint_up),
    .setpoint_down(setpoint_down), .edit_active(edit_active));

// File: tb/kmd_operator.sv
/*
 * Operator model: presses keys and turns the encoder one step.
 * Assumes the bench calls its tasks; pins change after rising edges.
 */
`timescale 1ns/1ns
module kmd_operator (
    input  wire core_clk,
    output reg  prog_pin,
    output reg  enter_pin,
    output reg  enc_a,
    output reg  enc_b
);
    initial begin
        prog_pin = 1'b0;
        enter_pin = 1'b0;
        enc_a = 1'b0;
        enc_b = 1'b0;
    end
    // Hold high and low long enough for the two-stage sync
    task press(input sel_enter);
        begin
            @(posedge core_clk);
            prog_pin <= !sel_enter;
            enter_pin <= sel_enter;
            repeat (4) @(posedge core_clk);
            prog_pin <= 1'b0;
            enter_pin <= 1'b0;
            repeat (5) @(posedge core_clk);
        end
    endtask
    task turn(input cw);
        begin
            @(posedge core_clk);
            enc_b <= !cw;
            @(posedge core_clk);
            enc_a <= 1'b1;
            repeat (4) @(posedge core_clk);
            enc_a <= 1'b0;
            repeat (5) @(posedge core_clk);
        end
    endtask
endmodule

// File: tb/tb_top.sv
/*
 * Self-checking bench of the panel controller.
 * Assumes the operator model on the key pins and storage read data
 * formed from the address.
 */
`timescale 1ns/1ns
`include "kmd_defines.vh"
module tb_top;
    reg         core_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         drive_running = 1'b0, drive_dir_fwd = 1'b0, run_src_keypad = 1'b1;
    reg         fault_active = 1'b0, warning_active = 1'b0, keypad_setting_en = 1'b0;
    reg  [7:0]  fault_code = 8'h5A, warning_code = 8'h3C;
    reg  [15:0] monitor_value = 16'hC0DE;
    wire        prog_pin, enter_pin, enc_a, enc_b;
    wire [27:0] seg_out;
    wire        running_lamp, forward_lamp, reverse_lamp, remote_lamp, fault_lamp;
    wire [11:0] param_addr;
    wire        param_wr_en, setpoint_up, setpoint_down, edit_active;
    wire [15:0] param_wr_data;
    wire [15:0] param_rd_data = {4'h0, param_addr};
    reg  [7:0]  errors = 8'h00, total_checks = 8'h00, n_wr = 8'h00, n_up = 8'h00, n_dn = 8'h00;
    reg  [27:0] wr_seen = 28'h0;
    integer     cyc = 0;
    localparam [6:0] D = `KMD_SEG_DASH;
    localparam [6:0] P = `KMD_SEG_P;
    localparam [111:0] HEX = {7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77, 7'h6F, 7'h7F,
                              7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};

    always #4 core_clk = ~core_clk;

    kmd_operator op (.core_clk(core_clk), .prog_pin(prog_pin), .enter_pin(enter_pin),
        .enc_a(enc_a), .enc_b(enc_b));
    kmd_panel_ctrl #(.BLINK_HALF_CYC(8)) DUT (.core_clk(core_clk), .reset_n(reset_n),
        .program_exit_key(prog_pin), .enter_key(enter_pin), .enc_a(enc_a), .enc_b(enc_b),
        .drive_running(drive_running), .drive_dir_fwd(drive_dir_fwd),
        .run_src_keypad(run_src_keypad), .fault_active(fault_active), .fault_code(fault_code),
        .warning_active(warning_active), .warning_code(warning_code),
        .monitor_value(monitor_value), .keypad_setting_en(keypad_setting_en),
        .param_rd_data(param_rd_data), .seg_out(seg_out), .running_lamp(running_lamp),
        .forward_lamp(forward_lamp), .reverse_lamp(reverse_lamp), .remote_lamp(remote_lamp),
        .fault_lamp(fault_lamp), .param_addr(param_addr), .param_wr_en(param_wr_en),
        .param_wr_data(param_wr_data), .setpoint_up(setpoint_up),
        .setpoint_down(setpoint_down), .edit_active(edit_active));

    function [6:0] hx(input [3:0] n);
        hx = HEX[n*7 +: 7];
    endfunction
    function [27:0] hex4(input [15:0] v);
        hex4 = {hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
    endfunction

    task chk(input [27:0] seen, input [27:0] exp);
        begin
            total_checks = total_checks + 8'h01;
            if (seen !== exp) begin
                errors = errors + 8'h01;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 8'h00 && total_checks != 8'h00)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task settle;
        begin
            repeat (3) @(posedge core_clk);
            #1;
        end
    endtask

    // ------------------------------------------------------------
    // Side counters and hang limit
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (param_wr_en === 1'b1) begin
            n_wr = n_wr + 8'h01;
            wr_seen = {param_addr, param_wr_data};
        end
        if (setpoint_up === 1'b1) n_up = n_up + 8'h01;
        if (setpoint_down === 1'b1) n_dn = n_dn + 8'h01;
        if (cyc == 6000) begin
            errors = errors + 8'h01;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_lamps;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                @(posedge core_clk);
                {drive_running, drive_dir_fwd, run_src_keypad} <= i[2:0];
                fault_active <= i[0];
                settle;
                chk({running_lamp, forward_lamp, reverse_lamp, remote_lamp, fault_lamp},
                    {i[2], i[2] & i[1], i[2] & ~i[1], ~i[0], i[0]});
            end
            fault_active <= 1'b0;
            $display("lamps done");
        end
    endtask
    task t_menu;
        reg lit, dark;
        begin
            lit = 1'b0;
            dark = 1'b0;
            op.press(1'b0);
            chk(seg_out, {D, P, hx(4'h0), D});
            op.turn(1'b1);
            chk(seg_out, {D, P, hx(4'h1), D});
            op.turn(1'b0);
            op.turn(1'b0);
            chk(seg_out, {D, P, hx(4'hF), D});
            op.press(1'b1);
            chk(seg_out, {P, hx(4'hF), hx(4'h0), hx(4'h0)});
            op.turn(1'b0);
            chk(seg_out, {P, hx(4'hF), hx(4'h6), hx(4'h3)});
            op.press(1'b1);
            chk(edit_active, 1'b1);
            op.turn(1'b1);
            repeat (20) begin
                @(posedge core_clk);
                #1;
                if (seg_out[6:0] === hx(4'h4)) lit = 1'b1;
                if (seg_out[6:0] === `KMD_SEG_BLANK) dark = 1'b1;
            end
            chk(seg_out[27:7], {hx(4'h0), hx(4'hF), hx(4'h6)});
            chk({lit, dark}, 2'b11);
            op.press(1'b1);
            chk({n_wr, wr_seen}, {8'h01, 12'hF63, 16'h0F64});
            chk(edit_active, 1'b0);
            op.press(1'b1);
            op.press(1'b0);
            chk({edit_active, seg_out}, {1'b0, P, hx(4'hF), hx(4'h6), hx(4'h3)});
            op.press(1'b0);
            chk(seg_out, {D, P, hx(4'hF), D});
            op.press(1'b0);
            chk(seg_out, hex4(16'hC0DE));
            $display("menu done");
        end
    endtask
    task t_alarm;
        begin
            @(posedge core_clk);
            fault_active <= 1'b1;
            settle;
            chk(seg_out, {hx(4'hE), D, hx(4'h5), hx(4'hA)});
            op.press(1'b0);
            chk({seg_out[27:14], seg_out[6:0]}, {D, P, D});
            op.press(1'b0);
            chk(seg_out, {hx(4'hE), D, hx(4'h5), hx(4'hA)});
            fault_code <= 8'h7B;
            settle;
            chk(seg_out, {hx(4'hE), D, hx(4'h7), hx(4'hB)});
            fault_active <= 1'b0;
            warning_active <= 1'b1;
            settle;
            chk(seg_out, {hx(4'hA), D, hx(4'h3), hx(4'hC)});
            op.press(1'b0);
            chk({seg_out[27:14], seg_out[6:0]}, {D, P, D});
            op.press(1'b0);
            chk(seg_out, {hx(4'hA), D, hx(4'h3), hx(4'hC)});
            warning_code <= 8'h96;
            settle;
            chk(seg_out, {hx(4'hA), D, hx(4'h9), hx(4'h6)});
            warning_active <= 1'b0;
            settle;
            chk(seg_out, hex4(16'hC0DE));
            monitor_value <= 16'h1234;
            settle;
            chk(seg_out, hex4(16'h1234));
            $display("alarm done");
        end
    endtask
    task t_setpoint;
        begin
            @(posedge core_clk);
            keypad_setting_en <= 1'b1;
            op.turn(1'b1);
            op.turn(1'b0);
            op.turn(1'b1);
            chk({n_up, n_dn}, {8'h02, 8'h01});
            op.press(1'b1);
            chk({edit_active, seg_out}, {1'b0, hex4(16'h1234)});
            keypad_setting_en <= 1'b0;
            op.turn(1'b1);
            chk(n_up, 8'h02);
            $display("setpoint done");
        end
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        settle;
        chk({edit_active, param_wr_en}, 2'b00);
        chk(seg_out, hex4(16'hC0DE));
        t_lamps;
        t_menu;
        t_alarm;
        t_setpoint;
        tally_and_finish;
    end
endmodule
